// ===== pkg/mem_map_pkg.sv
`default_nettype none
package mem_map_pkg;

   localparam logic [31:0] FLASH_BASE = 32'h0000_0000;
   localparam int FLASH_PAGES = 64;
   localparam int PAGE_BITS = 12;
   localparam int FLASH_PAGE_W = 6;
   localparam logic [31:0] CODE_RAM_BASE = 32'h0080_0000;
   localparam logic [31:0] DATA_RAM_BASE = 32'h2000_0000;
   localparam int RAM_SECTIONS = 8;
   localparam int RAM_PORTS = 4;
   localparam int RAM_ADDR_W = 15;
   localparam logic [31:0] FACTORY_INFO_BASE = 32'h1000_0000;
   localparam logic [31:0] USER_CONFIG_BASE = 32'h1000_1000;
   localparam logic [31:0] APB_PERIPH_BASE = 32'h4000_0000;
   localparam logic [31:0] AHB_PERIPH_BASE = 32'h5000_0000;
   localparam int SLOT_W = 6;
   // one bit per populated 4 kB slot above the peripheral base
   localparam logic [63:0] SLOT_MAP = 64'h0000_0080_C7FF_FF5F;
   localparam logic [5:0] SERIAL_SLOT = 6'h03;
   localparam logic [5:0] CRYPTO_SLOT = 6'h0F;
   localparam logic [1:0] FLASH_WAIT = 2'h2;
   localparam logic [1:0] RAM_WAIT = 2'h0;

   localparam logic [1:0] MASTER_INSTR = 2'h0;
   localparam logic [1:0] MASTER_DATA = 2'h1;
   localparam logic [1:0] MASTER_DMA = 2'h2;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_WAIT = 3'b010,
      ST_RESP = 3'b100
   } xfer_state_t;

endpackage
`default_nettype wire

// ===== rtl/wait_counter.sv
`timescale 1ns/1ps
`default_nettype none
module wait_counter #(
   parameter int WIDTH = 2
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic load,
   input wire logic [WIDTH-1:0] load_val,
   output logic expired
);
   logic [WIDTH-1:0] count_ff;
   logic [WIDTH-1:0] nxt_count;

   always_comb begin
      nxt_count = count_ff;
      if (load) begin
         nxt_count = load_val;
      end else if (count_ff != '0) begin
         nxt_count = count_ff - {{(WIDTH-1){1'b0}}, 1'b1};
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         count_ff <= '0;
      end else begin
         count_ff <= nxt_count;
      end
   end

   assign expired = (count_ff == '0);
endmodule
`default_nettype wire

// ===== rtl/memory_map_decoder.sv
`timescale 1ns/1ps
`default_nettype none
module memory_map_decoder
   import mem_map_pkg::*;
(
   input wire logic MCLK,
   input wire logic RESET,
   input wire logic REQ,
   input wire logic [31:0] ADDR,
   input wire logic WRITE,
   input wire logic [1:0] MASTER,
   input wire logic [1:0] SERIAL_SHARE_SEL,
   input wire logic CRYPTO_SHARE_SEL,
   input wire logic [RAM_SECTIONS-1:0] RAM_ON_PWR,
   input wire logic [RAM_SECTIONS-1:0] RAM_OFF_PWR,
   input wire logic SYSTEM_OFF,
   input wire logic CPU_RUNNING,
   input wire logic DEBUG_MODE,
   output logic BUSY,
   output logic DONE,
   output logic ERROR,
   output logic FLASH_SEL,
   output logic FLASH_IBUS,
   output logic [FLASH_PAGE_W-1:0] FLASH_PAGE,
   output logic RAM_SEL,
   output logic [1:0] RAM_PORT,
   output logic [RAM_ADDR_W-1:0] RAM_ADDR,
   output logic FACTORY_INFO_SEL,
   output logic USER_CONFIG_SEL,
   output logic PERIPH_SEL,
   output logic [SLOT_W-1:0] PERIPH_SLOT,
   output logic [3:0] SERIAL_SEL,
   output logic [1:0] CRYPTO_SEL,
   output logic [RAM_SECTIONS-1:0] RAM_SECTION_PWR,
   output logic TICK_ENABLE
);

   ////////////////////////////////////////////////////////////////////////////
   // address decode of the incoming request
   logic hit_flash, hit_code_ram, hit_data_ram, hit_ram;
   logic hit_factory, hit_user, hit_apb, hit_ahb, hit_periph;
   logic is_dma, deny;
   logic [2:0] section;
   logic [SLOT_W-1:0] slot;
   logic [1:0] wait_val;

   always_comb begin
      hit_flash = (ADDR[31:PAGE_BITS+FLASH_PAGE_W] == FLASH_BASE[31:PAGE_BITS+FLASH_PAGE_W]);
      hit_code_ram = (ADDR[31:RAM_ADDR_W] == CODE_RAM_BASE[31:RAM_ADDR_W]);
      hit_data_ram = (ADDR[31:RAM_ADDR_W] == DATA_RAM_BASE[31:RAM_ADDR_W]);
      hit_ram = hit_code_ram | hit_data_ram;
      hit_factory = (ADDR[31:PAGE_BITS] == FACTORY_INFO_BASE[31:PAGE_BITS]);
      hit_user = (ADDR[31:PAGE_BITS] == USER_CONFIG_BASE[31:PAGE_BITS]);
      slot = ADDR[PAGE_BITS+SLOT_W-1:PAGE_BITS];
      hit_apb = (ADDR[31:PAGE_BITS+SLOT_W] == APB_PERIPH_BASE[31:PAGE_BITS+SLOT_W])
         && SLOT_MAP[slot];
      hit_ahb = (ADDR[31:PAGE_BITS] == AHB_PERIPH_BASE[31:PAGE_BITS]);
      hit_periph = hit_apb | hit_ahb;
      section = ADDR[RAM_ADDR_W-1:PAGE_BITS];
      is_dma = (MASTER == MASTER_DMA);
      // dma masters only see memory, never peripheral registers
      deny = 1'b1;
      if (hit_flash || hit_factory || hit_user) begin
         // stores into nonvolatile space go via the write controller slot only
         deny = WRITE;
      end else if (hit_ram) begin
         // unpowered section cannot answer, so refuse rather than hang
         deny = !RAM_SECTION_PWR[section];
      end else if (hit_periph) begin
         deny = is_dma;
      end
      wait_val = (hit_flash && !deny) ? FLASH_WAIT : RAM_WAIT;
   end

   ////////////////////////////////////////////////////////////////////////////
   // transfer sequencing
   xfer_state_t state_ff, nxt_state;
   logic take, expired;
   logic busy_ff, nxt_busy;
   logic done_ff, nxt_done;
   logic error_ff, nxt_error, err_pend_ff, nxt_err_pend;
   logic flash_sel_ff, nxt_flash_sel, flash_ibus_ff, nxt_flash_ibus;
   logic [FLASH_PAGE_W-1:0] flash_page_ff, nxt_flash_page;
   logic ram_sel_ff, nxt_ram_sel;
   logic [1:0] ram_port_ff, nxt_ram_port;
   logic [RAM_ADDR_W-1:0] ram_addr_ff, nxt_ram_addr;
   logic factory_ff, nxt_factory, user_ff, nxt_user;
   logic periph_ff, nxt_periph;
   logic [SLOT_W-1:0] slot_ff, nxt_slot;
   logic [3:0] serial_ff, nxt_serial;
   logic [1:0] crypto_ff, nxt_crypto;

   assign take = (state_ff == ST_IDLE) && REQ;

   wait_counter #(
      .WIDTH(2)
   ) u_wait (
      .clk(MCLK),
      .reset(RESET),
      .load(take),
      .load_val(wait_val),
      .expired(expired)
   );

   always_comb begin
      nxt_state = state_ff;
      nxt_done = 1'b0;
      nxt_error = 1'b0;
      nxt_err_pend = err_pend_ff;
      nxt_flash_sel = flash_sel_ff;
      nxt_flash_ibus = flash_ibus_ff;
      nxt_flash_page = flash_page_ff;
      nxt_ram_sel = ram_sel_ff;
      nxt_ram_port = ram_port_ff;
      nxt_ram_addr = ram_addr_ff;
      nxt_factory = factory_ff;
      nxt_user = user_ff;
      nxt_periph = periph_ff;
      nxt_slot = slot_ff;
      nxt_serial = serial_ff;
      nxt_crypto = crypto_ff;
      unique case (state_ff)
         ST_IDLE: begin
            if (REQ) begin
               nxt_state = ST_WAIT;
               nxt_err_pend = deny;
               nxt_flash_sel = hit_flash && !deny;
               nxt_flash_ibus = (MASTER == MASTER_INSTR);
               nxt_flash_page = ADDR[PAGE_BITS+FLASH_PAGE_W-1:PAGE_BITS];
               nxt_ram_sel = hit_ram && !deny;
               nxt_ram_port = section[2:1];
               // both windows land on the same cell: only low bits kept
               nxt_ram_addr = ADDR[RAM_ADDR_W-1:0];
               nxt_factory = hit_factory && !deny;
               nxt_user = hit_user && !deny;
               nxt_periph = hit_periph && !deny;
               nxt_slot = hit_apb ? slot : '0;
               nxt_serial = 4'h0;
               if (hit_apb && !deny && slot == SERIAL_SLOT) begin
                  nxt_serial[SERIAL_SHARE_SEL] = 1'b1;
               end
               nxt_crypto = 2'h0;
               if (hit_apb && !deny && slot == CRYPTO_SLOT) begin
                  nxt_crypto[CRYPTO_SHARE_SEL] = 1'b1;
               end
            end
         end
         ST_WAIT: begin
            if (expired) begin
               nxt_state = ST_RESP;
               nxt_done = 1'b1;
               nxt_error = err_pend_ff;
            end
         end
         ST_RESP: begin
            nxt_state = ST_IDLE;
            nxt_err_pend = 1'b0;
            nxt_flash_sel = 1'b0;
            nxt_ram_sel = 1'b0;
            nxt_factory = 1'b0;
            nxt_user = 1'b0;
            nxt_periph = 1'b0;
            nxt_serial = 4'h0;
            nxt_crypto = 2'h0;
         end
         default: begin
            nxt_state = ST_IDLE;
         end
      endcase
      // status pin registered so it never glitches on a state decode
      nxt_busy = (nxt_state != ST_IDLE);
   end

   always_ff @(posedge MCLK) begin
      if (RESET) begin
         state_ff <= ST_IDLE;
         busy_ff <= 1'b0;
         done_ff <= 1'b0;
         error_ff <= 1'b0;
         err_pend_ff <= 1'b0;
         flash_sel_ff <= 1'b0;
         flash_ibus_ff <= 1'b0;
         flash_page_ff <= '0;
         ram_sel_ff <= 1'b0;
         ram_port_ff <= 2'h0;
         ram_addr_ff <= '0;
         factory_ff <= 1'b0;
         user_ff <= 1'b0;
         periph_ff <= 1'b0;
         slot_ff <= '0;
         serial_ff <= 4'h0;
         crypto_ff <= 2'h0;
      end else begin
         state_ff <= nxt_state;
         busy_ff <= nxt_busy;
         done_ff <= nxt_done;
         error_ff <= nxt_error;
         err_pend_ff <= nxt_err_pend;
         flash_sel_ff <= nxt_flash_sel;
         flash_ibus_ff <= nxt_flash_ibus;
         flash_page_ff <= nxt_flash_page;
         ram_sel_ff <= nxt_ram_sel;
         ram_port_ff <= nxt_ram_port;
         ram_addr_ff <= nxt_ram_addr;
         factory_ff <= nxt_factory;
         user_ff <= nxt_user;
         periph_ff <= nxt_periph;
         slot_ff <= nxt_slot;
         serial_ff <= nxt_serial;
         crypto_ff <= nxt_crypto;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // section power and tick gating
   logic [RAM_SECTIONS-1:0] pwr_ff, nxt_pwr;
   logic tick_ff, nxt_tick;

   always_comb begin
      nxt_pwr = SYSTEM_OFF ? RAM_OFF_PWR : RAM_ON_PWR;
      nxt_tick = CPU_RUNNING | DEBUG_MODE;
   end

   always_ff @(posedge MCLK) begin
      if (RESET) begin
         pwr_ff <= '0;
         tick_ff <= 1'b0;
      end else begin
         pwr_ff <= nxt_pwr;
         tick_ff <= nxt_tick;
      end
   end

   assign BUSY = busy_ff;
   assign DONE = done_ff;
   assign ERROR = error_ff;
   assign FLASH_SEL = flash_sel_ff;
   assign FLASH_IBUS = flash_ibus_ff;
   assign FLASH_PAGE = flash_page_ff;
   assign RAM_SEL = ram_sel_ff;
   assign RAM_PORT = ram_port_ff;
   assign RAM_ADDR = ram_addr_ff;
   assign FACTORY_INFO_SEL = factory_ff;
   assign USER_CONFIG_SEL = user_ff;
   assign PERIPH_SEL = periph_ff;
   assign PERIPH_SLOT = slot_ff;
   assign SERIAL_SEL = serial_ff;
   assign CRYPTO_SEL = crypto_ff;
   assign RAM_SECTION_PWR = pwr_ff;
   assign TICK_ENABLE = tick_ff;
endmodule
`default_nettype wire

// ===== bench/memory_map_decoder_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module memory_map_decoder_asserts
   import mem_map_pkg::*;
(
   input wire logic MCLK,
   input wire logic RESET,
   input wire logic REQ,
   input wire logic [31:0] ADDR,
   input wire logic WRITE,
   input wire logic BUSY,
   input wire logic DONE,
   input wire logic ERROR,
   input wire logic FLASH_SEL,
   input wire logic [FLASH_PAGE_W-1:0] FLASH_PAGE,
   input wire logic RAM_SEL,
   input wire logic [1:0] RAM_PORT,
   input wire logic [RAM_ADDR_W-1:0] RAM_ADDR,
   input wire logic PERIPH_SEL,
   input wire logic [3:0] SERIAL_SEL,
   input wire logic CPU_RUNNING,
   input wire logic DEBUG_MODE,
   input wire logic TICK_ENABLE
);
   default clocking @(posedge MCLK); endclocking
   default disable iff (RESET);
   logic take;
   assign take = REQ && !BUSY;
   sequence s_wait2;
      !DONE ##1 !DONE;
   endsequence
   property p_take; take |=> BUSY; endproperty
   a_take: assert property (p_take) else $error("busy missing");
   property p_pulse; DONE |=> !DONE; endproperty
   a_pulse: assert property (p_pulse) else $error("done too long");
   property p_err; ERROR |-> DONE; endproperty
   a_err: assert property (p_err) else $error("error without done");
   property p_ram; $rose(RAM_SEL) |=> DONE; endproperty
   a_ram: assert property (p_ram) else $error("ram wait wrong");
   property p_flash; $rose(FLASH_SEL) |=> s_wait2 ##1 DONE; endproperty
   a_flash: assert property (p_flash) else $error("flash wait wrong");
   property p_page; $rose(FLASH_SEL) |-> FLASH_PAGE == $past(ADDR[17:12]); endproperty
   a_page: assert property (p_page) else $error("page wrong");
   property p_port; RAM_SEL |-> RAM_PORT == RAM_ADDR[14:13]; endproperty
   a_port: assert property (p_port) else $error("port wrong");
   property p_nowr; take && WRITE && ADDR < 32'h0004_0000 |=> !FLASH_SEL ##1 ERROR; endproperty
   a_nowr: assert property (p_nowr) else $error("flash store taken");
   property p_unmap; take && ADDR[31:28] == 4'h3 |=> ##1 ERROR; endproperty
   a_unmap: assert property (p_unmap) else $error("no bus error");
   property p_tick;
      !$past(RESET) |-> TICK_ENABLE == ($past(CPU_RUNNING) || $past(DEBUG_MODE));
   endproperty
   a_tick: assert property (p_tick) else $error("tick gate wrong");
   property p_ser; SERIAL_SEL != 4'h0 |-> $onehot(SERIAL_SEL) && PERIPH_SEL; endproperty
   a_ser: assert property (p_ser) else $error("serial owner wrong");
endmodule
bind memory_map_decoder memory_map_decoder_asserts memory_map_decoder_asserts_inst (
   .MCLK(MCLK), .RESET(RESET), .REQ(REQ), .ADDR(ADDR), .WRITE(WRITE), .BUSY(BUSY),
   .DONE(DONE), .ERROR(ERROR), .FLASH_SEL(FLASH_SEL), .FLASH_PAGE(FLASH_PAGE),
   .RAM_SEL(RAM_SEL), .RAM_PORT(RAM_PORT), .RAM_ADDR(RAM_ADDR), .PERIPH_SEL(PERIPH_SEL),
   .SERIAL_SEL(SERIAL_SEL), .CPU_RUNNING(CPU_RUNNING), .DEBUG_MODE(DEBUG_MODE),
   .TICK_ENABLE(TICK_ENABLE));
`default_nettype wire

// ===== bench/bus_master_model.sv
`timescale 1ns/1ps
`default_nettype none
module bus_master_model (
   input wire logic clk,
   input wire logic done,
   input wire logic error,
   input wire logic [11:0] sels,
   output logic req,
   output logic [31:0] addr,
   output logic wr,
   output logic [1:0] mst
);
   logic [11:0] snap;
   int lat;
   logic err;
   initial begin
      req = 1'b0;
      addr = 32'h0;
      wr = 1'b0;
      mst = 2'h0;
   end
   task automatic xfer(input logic [31:0] a, input logic w, input logic [1:0] m);
      @(negedge clk);
      req = 1'b1;
      addr = a;
      wr = w;
      mst = m;
      @(negedge clk);
      // released fields flip so stale values never look valid
      req = 1'b0;
      addr = ~a;
      wr = ~w;
      mst = ~m;
      snap = sels;
      lat = 1;
      while (done !== 1'b1 && lat < 8) begin
         @(negedge clk);
         lat++;
      end
      err = error;
   endtask
endmodule
`default_nettype wire

// ===== bench/memory_map_decoder_test.sv
`timescale 1ns/1ps
`default_nettype none
module memory_map_decoder_test
   import mem_map_pkg::*;
;
   logic MCLK = 1'b0;
   logic RESET = 1'b1;
   logic REQ, WRITE, BUSY, DONE, ERROR, FLASH_SEL, FLASH_IBUS, RAM_SEL, TICK_ENABLE;
   logic FACTORY_INFO_SEL, USER_CONFIG_SEL, PERIPH_SEL;
   logic CRYPTO_SHARE_SEL = 1'b0, SYSTEM_OFF = 1'b0, CPU_RUNNING = 1'b0, DEBUG_MODE = 1'b0;
   logic [1:0] SERIAL_SHARE_SEL = 2'h0;
   logic [1:0] MASTER, RAM_PORT, CRYPTO_SEL;
   logic [31:0] ADDR;
   logic [RAM_SECTIONS-1:0] RAM_ON_PWR = 8'hFF, RAM_OFF_PWR = 8'hFF, RAM_SECTION_PWR;
   logic [FLASH_PAGE_W-1:0] FLASH_PAGE;
   logic [SLOT_W-1:0] PERIPH_SLOT;
   logic [RAM_ADDR_W-1:0] RAM_ADDR;
   logic [3:0] SERIAL_SEL;
   int n_mismatch = 0;
   int compares = 0;
   always #10 MCLK = ~MCLK;
   memory_map_decoder memory_map_decoder_inst (
      .MCLK(MCLK), .RESET(RESET), .REQ(REQ), .ADDR(ADDR), .WRITE(WRITE), .MASTER(MASTER),
      .SERIAL_SHARE_SEL(SERIAL_SHARE_SEL), .CRYPTO_SHARE_SEL(CRYPTO_SHARE_SEL),
      .RAM_ON_PWR(RAM_ON_PWR), .RAM_OFF_PWR(RAM_OFF_PWR), .SYSTEM_OFF(SYSTEM_OFF),
      .CPU_RUNNING(CPU_RUNNING), .DEBUG_MODE(DEBUG_MODE), .BUSY(BUSY), .DONE(DONE),
      .ERROR(ERROR), .FLASH_SEL(FLASH_SEL), .FLASH_IBUS(FLASH_IBUS), .FLASH_PAGE(FLASH_PAGE),
      .RAM_SEL(RAM_SEL), .RAM_PORT(RAM_PORT), .RAM_ADDR(RAM_ADDR),
      .FACTORY_INFO_SEL(FACTORY_INFO_SEL), .USER_CONFIG_SEL(USER_CONFIG_SEL),
      .PERIPH_SEL(PERIPH_SEL), .PERIPH_SLOT(PERIPH_SLOT), .SERIAL_SEL(SERIAL_SEL),
      .CRYPTO_SEL(CRYPTO_SEL), .RAM_SECTION_PWR(RAM_SECTION_PWR), .TICK_ENABLE(TICK_ENABLE));
   bus_master_model bus_master_model_inst (
      .clk(MCLK), .done(DONE), .error(ERROR), .req(REQ), .addr(ADDR), .wr(WRITE), .mst(MASTER),
      .sels({FLASH_SEL, FLASH_IBUS, RAM_SEL, FACTORY_INFO_SEL, USER_CONFIG_SEL, PERIPH_SEL,
             SERIAL_SEL, CRYPTO_SEL}));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic complete_run;
      $display("compares %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected %s expected %0h seen %0h", what, exp, got);
      end
   endtask
   // one transfer, judged on selects seen in cycle 1, latency and error
   task automatic run(input logic [31:0] a, input logic w, input logic [1:0] m,
                      input logic [11:0] s, input int l, input logic e);
      bus_master_model_inst.xfer(a, w, m);
      cmp("selects", 32'(s), 32'(bus_master_model_inst.snap));
      cmp("latency", l, bus_master_model_inst.lat);
      cmp("error", 32'(e), 32'(bus_master_model_inst.err));
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_ram;
      run(32'h2000_1004, 1'b0, 2'h1, 12'h200, 2, 1'b0);
      cmp("ram_addr", 32'h1004, 32'(RAM_ADDR));
      cmp("ram_port", 32'h0, 32'(RAM_PORT));
      run(32'h0080_7FFC, 1'b1, 2'h2, 12'h200, 2, 1'b0);
      cmp("ram_addr", 32'h7FFC, 32'(RAM_ADDR));
      cmp("ram_port", 32'h3, 32'(RAM_PORT));
      $display("test ram done");
   endtask
   task automatic t_flash;
      run(32'h0000_3000, 1'b0, 2'h0, 12'hC00, 4, 1'b0);
      cmp("page", 32'h3, 32'(FLASH_PAGE));
      run(32'h0003_FFFC, 1'b0, 2'h1, 12'h800, 4, 1'b0);
      cmp("page", 32'h3F, 32'(FLASH_PAGE));
      run(32'h0000_0100, 1'b1, 2'h1, 12'h000, 2, 1'b1);
      run(32'h0004_0000, 1'b0, 2'h1, 12'h000, 2, 1'b1);
      $display("test flash done");
   endtask
   task automatic t_regions;
      run(32'h1000_0000, 1'b0, 2'h1, 12'h100, 2, 1'b0);
      run(32'h1000_1FFC, 1'b0, 2'h1, 12'h080, 2, 1'b0);
      run(32'h1000_0004, 1'b1, 2'h1, 12'h000, 2, 1'b1);
      run(32'h4000_8000, 1'b1, 2'h1, 12'h040, 2, 1'b0);
      cmp("slot", 32'h8, 32'(PERIPH_SLOT));
      run(32'h4000_8000, 1'b0, 2'h2, 12'h000, 2, 1'b1);
      run(32'h4000_5000, 1'b0, 2'h1, 12'h000, 2, 1'b1);
      run(32'h3000_0000, 1'b0, 2'h1, 12'h000, 2, 1'b1);
      $display("test regions done");
   endtask
   task automatic t_shares;
      for (int k = 0; k < 4; k++) begin
         SERIAL_SHARE_SEL = k[1:0];
         run(32'h4000_3000, 1'b0, 2'h1, 12'h040 | (12'h004 << k), 2, 1'b0);
      end
      for (int k = 0; k < 2; k++) begin
         CRYPTO_SHARE_SEL = k[0];
         run(32'h4000_F000, 1'b0, 2'h1, 12'h040 | (12'h001 << k), 2, 1'b0);
      end
      $display("test shares done");
   endtask
   task automatic t_power;
      RAM_ON_PWR = 8'hDF;
      repeat (2) @(negedge MCLK);
      run(32'h2000_5000, 1'b0, 2'h1, 12'h000, 2, 1'b1);
      run(32'h2000_4000, 1'b0, 2'h1, 12'h200, 2, 1'b0);
      SYSTEM_OFF = 1'b1;
      RAM_OFF_PWR = 8'h3C;
      repeat (2) @(negedge MCLK);
      cmp("pwr", 32'h3C, 32'(RAM_SECTION_PWR));
      SYSTEM_OFF = 1'b0;
      RAM_ON_PWR = 8'hFF;
      $display("test power done");
   endtask
   task automatic t_tick;
      for (int k = 0; k < 4; k++) begin
         {CPU_RUNNING, DEBUG_MODE} = k[1:0];
         repeat (2) @(negedge MCLK);
         cmp("tick", 32'(k != 0), 32'(TICK_ENABLE));
      end
      $display("test tick done");
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (5) @(negedge MCLK);
      RESET = 1'b0;
      cmp("idle", 32'h0, 32'({BUSY, DONE, ERROR, RAM_SEL, FLASH_SEL, PERIPH_SEL}));
      t_ram();
      t_flash();
      t_regions();
      t_shares();
      t_power();
      t_tick();
      complete_run();
   end
   // whole run is under a hundred cycles
   initial begin
      #100000;
      n_mismatch++;
      complete_run();
   end
endmodule
`default_nettype wire
